// *** hw/pdtc_pll_divider_trigger_output.v ***
// Configuration slice: PLL feedback dividers, oscillator bias, lane
// pre-emphasis and trigger output control, with the divider and trigger logic.
// Assumes a register port decoded by the serial interface outside, synchronous
// to clk, and a serializer bit-rate strobe that marks one unit interval.
//
// Overview of operation
// - Second divider code 0,1,2 divides by 1,2,4; code 3 reserved; reset by one.
// - Second divider output is the sampling clock.
// - First divider code 0,1,2 divides by 5,4,3; code 3 reserved; reset by five.
// - First divider output feeds the second divider input, cascaded.
// - Third divider divides by programmed value 1 to 63; reset 32.
// - Sampling clock divided by third divider forms the detector feedback clock.
// - One pre-emphasis setting applies to every serial lane at once.
// - Trigger enable bit 7 low disables, high enables; reset disabled.
// - Select 0,1,2 give 16,32,64 UI clocks; 3 resampled timestamp; 4-7 reserved.
// - Modes 2 and below come from serializer clocking; stop during reinit.
`timescale 1ns/1ps
`include "pdtc_regs.vh"

module pdtc_pll_divider_trigger_output #(
  parameter LANES = 8
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Register port
  input  wire [6:0]       regAddr,
  input  wire [7:0]       regWrData,
  input  wire             regWrEn,
  input  wire             regRdEn,
  output reg  [7:0]       regRdData,
  // Clock sources
  input  wire             vcoTick,
  input  wire             serUiTick,
  input  wire             serReinit,
  input  wire             synthResetControl,
  input  wire             timestampInput,
  // Derived clocks and settings
  output reg              sampleClk,
  output reg              feedbackClk,
  output reg  [6:0]       oscillatorBiasLevel,
  output reg  [LANES*4-1:0] lanePreemphasisLevel,
  output reg              triggerOutput,
  output reg              triggerOutputEnable
);

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  reg [7:0] fbDiv12_r;
  reg [7:0] fbDiv3_r;
  reg [7:0] oscBias_r;
  reg [7:0] preEmph_r;
  reg [7:0] trigCtrl_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fbDiv12_r  <= `PDTC_RST_FBDIV12;
      fbDiv3_r   <= `PDTC_RST_FBDIV3;
      oscBias_r  <= `PDTC_RST_OSCBIAS;
      preEmph_r  <= `PDTC_RST_PREEMPH;
      trigCtrl_r <= `PDTC_RST_TRIGCTRL;
      regRdData  <= 8'h00;
    end else begin
      if (regWrEn) begin
        case (regAddr)
          `PDTC_ADDR_FBDIV12:  fbDiv12_r  <= regWrData;
          `PDTC_ADDR_FBDIV3:   fbDiv3_r   <= regWrData;
          `PDTC_ADDR_OSCBIAS:  oscBias_r  <= regWrData;
          `PDTC_ADDR_PREEMPH:  preEmph_r  <= regWrData;
          `PDTC_ADDR_TRIGCTRL: trigCtrl_r <= regWrData;
          default: begin
          end
        endcase
      end
      if (regRdEn) begin
        case (regAddr)
          `PDTC_ADDR_FBDIV12:  regRdData <= fbDiv12_r;
          `PDTC_ADDR_FBDIV3:   regRdData <= fbDiv3_r;
          `PDTC_ADDR_OSCBIAS:  regRdData <= oscBias_r;
          `PDTC_ADDR_PREEMPH:  regRdData <= preEmph_r;
          `PDTC_ADDR_TRIGCTRL: regRdData <= trigCtrl_r;
          default:             regRdData <= 8'h00;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Divider decode
  // --------------------------------------------------------------------------
  // Terminal counts are divisor minus one. Reserved codes fall back to the
  // reset division so a stray write cannot stop the clock.
  function [2:0] firstLast;
    input [1:0] code;
    begin
      case (code)
        2'h1:    firstLast = 3'h3;
        2'h2:    firstLast = 3'h2;
        default: firstLast = 3'h4;
      endcase
    end
  endfunction

  function [1:0] secondLast;
    input [1:0] code;
    begin
      case (code)
        2'h1:    secondLast = 2'h1;
        2'h2:    secondLast = 2'h3;
        default: secondLast = 2'h0;
      endcase
    end
  endfunction

  wire [2:0] div1Last = firstLast(fbDiv12_r[`PDTC_DIV1_MSB:`PDTC_DIV1_LSB]);
  wire [1:0] div2Last = secondLast(fbDiv12_r[`PDTC_DIV2_MSB:`PDTC_DIV2_LSB]);
  wire [5:0] div3Val  = fbDiv3_r[`PDTC_DIV3_MSB:0];

  // --------------------------------------------------------------------------
  // Feedback divider chain
  // --------------------------------------------------------------------------
  reg [2:0] div1Cnt_r;
  reg [1:0] div2Cnt_r;
  reg [5:0] div3Cnt_r;
  reg       div1Tick_r;
  reg       div2Tick_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div1Cnt_r   <= 3'h0;
      div2Cnt_r   <= 2'h0;
      div3Cnt_r   <= 6'h00;
      div1Tick_r  <= 1'b0;
      div2Tick_r  <= 1'b0;
      sampleClk   <= 1'b0;
      feedbackClk <= 1'b0;
    end else if (synthResetControl) begin
      // Holding the chain here is why divider changes want the synth reset.
      div1Cnt_r   <= 3'h0;
      div2Cnt_r   <= 2'h0;
      div3Cnt_r   <= 6'h00;
      div1Tick_r  <= 1'b0;
      div2Tick_r  <= 1'b0;
      sampleClk   <= 1'b0;
      feedbackClk <= 1'b0;
    end else begin
      div1Tick_r <= 1'b0;
      div2Tick_r <= 1'b0;
      if (vcoTick) begin
        if (div1Cnt_r >= div1Last) begin
          div1Cnt_r  <= 3'h0;
          div1Tick_r <= 1'b1;
        end else begin
          div1Cnt_r <= div1Cnt_r + 3'h1;
        end
      end
      if (div1Tick_r) begin
        if (div2Cnt_r >= div2Last) begin
          div2Cnt_r  <= 2'h0;
          div2Tick_r <= 1'b1;
        end else begin
          div2Cnt_r <= div2Cnt_r + 2'h1;
        end
      end
      sampleClk <= div2Tick_r;
      feedbackClk <= 1'b0;
      if (div2Tick_r) begin
        if (div3Cnt_r + 6'h01 >= div3Val) begin
          div3Cnt_r   <= 6'h00;
          feedbackClk <= 1'b1;
        end else begin
          div3Cnt_r <= div3Cnt_r + 6'h01;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Bias and pre-emphasis distribution
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : gLane
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          lanePreemphasisLevel[g*4+3:g*4] <= 4'h0;
        end else begin
          lanePreemphasisLevel[g*4+3:g*4] <= preEmph_r[`PDTC_PE_MSB:0];
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscillatorBiasLevel <= 7'h4F;
    end else begin
      oscillatorBiasLevel <= oscBias_r[`PDTC_BIAS_MSB:0];
    end
  end

  // --------------------------------------------------------------------------
  // Trigger output
  // --------------------------------------------------------------------------
  // All three bits of the select are decoded; codes 4-7 hold the output low.
  wire [2:0] trigSel = trigCtrl_r[`PDTC_TRIG_SEL_MSB:0];
  wire       trigEn  = trigCtrl_r[`PDTC_TRIG_EN_BIT];
  reg  [5:0] uiCnt_r;
  reg  [5:0] uiHalf;

  always @* begin
    case (trigSel)
      `PDTC_SEL_UI16: uiHalf = `PDTC_UI16_HALF;
      `PDTC_SEL_UI32: uiHalf = `PDTC_UI32_HALF;
      default:        uiHalf = `PDTC_UI64_HALF;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uiCnt_r             <= 6'h00;
      triggerOutput       <= 1'b0;
      triggerOutputEnable <= 1'b0;
    end else begin
      triggerOutputEnable <= trigEn;
      if (!trigEn || serReinit) begin
        uiCnt_r <= 6'h00;
        triggerOutput <= 1'b0;
      end else if (trigSel == `PDTC_SEL_TSTAMP) begin
        triggerOutput <= timestampInput;
      end else if (trigSel > `PDTC_SEL_TSTAMP) begin
        triggerOutput <= 1'b0;
      end else if (serUiTick) begin
        if (uiCnt_r >= uiHalf) begin
          uiCnt_r       <= 6'h00;
          triggerOutput <= ~triggerOutput;
        end else begin
          uiCnt_r <= uiCnt_r + 6'h01;
        end
      end
    end
  end

endmodule

// *** shared/pdtc_regs.vh ***
// Register offsets, field positions, reset values and codes of the PLL divider,
// oscillator bias, lane pre-emphasis and trigger output control registers.
// Assumes inclusion by bare name from the design file.
`ifndef PDTC_REGS_VH
`define PDTC_REGS_VH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PDTC_ADDR_FBDIV12     7'h3D
`define PDTC_ADDR_FBDIV3      7'h3E
`define PDTC_ADDR_OSCBIAS     7'h3F
`define PDTC_ADDR_PREEMPH     7'h48
`define PDTC_ADDR_TRIGCTRL    7'h57
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PDTC_RST_FBDIV12      8'h00
`define PDTC_RST_FBDIV3       8'h20
`define PDTC_RST_OSCBIAS      8'h4F
`define PDTC_RST_PREEMPH      8'h00
`define PDTC_RST_TRIGCTRL     8'h00
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PDTC_DIV1_LSB         0
`define PDTC_DIV1_MSB         1
`define PDTC_DIV2_LSB         2
`define PDTC_DIV2_MSB         3
`define PDTC_DIV3_MSB         5
`define PDTC_BIAS_MSB         6
`define PDTC_PE_MSB           3
`define PDTC_TRIG_EN_BIT      7
`define PDTC_TRIG_SEL_MSB     2
// ----------------------------------------------------------------------------
// Codes and recommended values
// ----------------------------------------------------------------------------
`define PDTC_SEL_UI16         3'h0
`define PDTC_SEL_UI32         3'h1
`define PDTC_SEL_UI64         3'h2
`define PDTC_SEL_TSTAMP       3'h3
`define PDTC_BIAS_RECOMMENDED 7'h4A
`define PDTC_UI16_HALF        6'h07
`define PDTC_UI32_HALF        6'h0F
`define PDTC_UI64_HALF        6'h1F
`endif

// *** test/pdtc_checker.sv ***
// Checker for the PLL divider and trigger output slice.
// Assumes the top module ports and one clock domain.
`timescale 1ns/1ps
module pdtc_checker #(
  parameter LANES = 8
) (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic [6:0]         regAddr,
  input wire logic [7:0]         regWrData,
  input wire logic               regWrEn,
  input wire logic               regRdEn,
  input wire logic [7:0]         regRdData,
  input wire logic               synthResetControl,
  input wire logic               sampleClk,
  input wire logic               feedbackClk,
  input wire logic [6:0]         oscillatorBiasLevel,
  input wire logic [LANES*4-1:0] lanePreemphasisLevel,
  input wire logic               triggerOutput,
  input wire logic               triggerOutputEnable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_bias_follow: assert property (regWrEn && regAddr == 7'h3F |-> ##2
    oscillatorBiasLevel == $past(regWrData[6:0], 2)) else $error("bias mismatch");
  a_trig_enable: assert property (regWrEn && regAddr == 7'h57 |-> ##2
    triggerOutputEnable == $past(regWrData[7], 2)) else $error("enable mismatch");
  a_lanes_equal: assert property (lanePreemphasisLevel ==
    {LANES{lanePreemphasisLevel[3:0]}}) else $error("lane setting differs");
  a_unmapped_zero: assert property (regRdEn &&
    !(regAddr inside {7'h3D, 7'h3E, 7'h3F, 7'h48, 7'h57}) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_synth_hold: assert property (synthResetControl [*2] |->
    !sampleClk && !feedbackClk) else $error("clock under synth reset");
  a_sample_pulse: assert property (sampleClk |=> !sampleClk)
    else $error("sample pulse too long");
  a_feedback_align: assert property (feedbackClk |-> sampleClk)
    else $error("feedback without sample");
  a_trig_off: assert property (!triggerOutputEnable && $past(!triggerOutputEnable)
    |-> !triggerOutput) else $error("trigger while disabled");
endmodule
bind pdtc_pll_divider_trigger_output pdtc_checker #(.LANES(LANES)) pdtc_checker_i (.clk, .rst_n,
  .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .synthResetControl, .sampleClk,
  .feedbackClk, .oscillatorBiasLevel, .lanePreemphasisLevel, .triggerOutput,
  .triggerOutputEnable);

// *** test/pdtc_host_model.sv ***
// Host model: drives the parallel register port of the slice.
// Assumes the slice samples the port on posedge clk; this model moves on negedge.
`timescale 1ns/1ps
module pdtc_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] regRdData,
  output logic      [6:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWrEn,
  output logic            regRdEn,
  output logic            synthResetControl
);
  initial begin
    regAddr = 7'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    synthResetControl = 1'b0;
  end
  // Released lines show the inverse so stale values never look valid.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    d = regRdData;
    regRdEn = 1'b0;
    regAddr = ~a;
  endtask
  task automatic div(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    synthResetControl = 1'b1;
    wr(a, d);
    @(negedge clk);
    synthResetControl = 1'b0;
  endtask
endmodule

// *** test/pdtc_pll_divider_trigger_output_bench.sv ***
// Testbench for the PLL divider and trigger output slice.
// Assumes ticks every second cycle, so every measured period is doubled.
`timescale 1ns/1ps
module pdtc_pll_divider_trigger_output_bench;
  logic clk = 1'b0, rst_n = 1'b0, vcoTick = 1'b0, serUiTick = 1'b0, run = 1'b0;
  logic serReinit = 1'b0, timestampInput = 1'b0;
  wire [6:0] regAddr, oscillatorBiasLevel;
  wire [7:0] regWrData, regRdData;
  wire [31:0] lanePreemphasisLevel;
  wire regWrEn, regRdEn, synthResetControl, sampleClk, feedbackClk;
  wire triggerOutput, triggerOutputEnable;
  int mismatches = 0, samples_checked = 0;
  always #2.5 clk = ~clk;
  always @(negedge clk) begin
    vcoTick <= run & ~vcoTick;
    serUiTick <= run & ~serUiTick;
  end
  pdtc_host_model pdtc_host_model_i (.clk, .regRdData, .regAddr, .regWrData, .regWrEn,
    .regRdEn, .synthResetControl);
  pdtc_pll_divider_trigger_output #(.LANES(8)) pdtc_pll_divider_trigger_output_i (.clk, .rst_n,
    .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .vcoTick, .serUiTick,
    .serReinit, .synthResetControl, .timestampInput, .sampleClk, .feedbackClk,
    .oscillatorBiasLevel, .lanePreemphasisLevel, .triggerOutput, .triggerOutputEnable);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    pdtc_host_model_i.wr(a, d);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    pdtc_host_model_i.rd(a, d);
    chk(d, e);
  endtask
  function automatic logic pick(int w);
    return w == 0 ? sampleClk : w == 1 ? feedbackClk : triggerOutput;
  endfunction
  task automatic rise(int w, output int n);
    logic p;
    p = pick(w);
    for (n = 1; n < 3000; n++) begin
      @(negedge clk);
      if (pick(w) && !p) break;
      p = pick(w);
    end
  endtask
  // Rise to rise, so a partial first period never counts.
  task automatic per(int w, int e);
    int n;
    rise(w, n);
    rise(w, n);
    chk(n, e);
  endtask
  task automatic test_regs;
    rdchk(7'h3D, 8'h00);
    rdchk(7'h3E, 8'h20);
    rdchk(7'h3F, 8'h4F);
    rdchk(7'h48, 8'h00);
    rdchk(7'h57, 8'h00);
    wr(7'h3F, 8'h4A);
    wr(7'h48, 8'h09);
    wr(7'h57, 8'h02);
    rdchk(7'h3F, 8'h4A);
    rdchk(7'h48, 8'h09);
    rdchk(7'h57, 8'h02);
    rdchk(7'h40, 8'h00);
    chk(oscillatorBiasLevel, 7'h4A);
    chk(lanePreemphasisLevel, {8{4'h9}});
    $display("test_regs done");
  endtask
  task automatic test_div;
    int d1[4] = '{5, 4, 3, 5};
    int d2[4] = '{1, 2, 4, 1};
    for (int i = 0; i < 16; i++) begin
      pdtc_host_model_i.div(7'h3D, {4'h0, i[3:2], i[1:0]});
      pdtc_host_model_i.div(7'h3E, 8'h03);
      per(0, 2 * d1[i[1:0]] * d2[i[3:2]]);
      per(1, 6 * d1[i[1:0]] * d2[i[3:2]]);
    end
    pdtc_host_model_i.div(7'h3E, 8'h3F);
    per(1, 2 * 5 * 63);
    $display("test_div done");
  endtask
  task automatic test_trig;
    logic seen;
    for (int m = 0; m < 3; m++) begin
      wr(7'h57, m[7:0]);
      wr(7'h57, 8'h80 | m[7:0]);
      @(negedge clk);
      chk(triggerOutputEnable, 1'b1);
      per(2, 32 << m);
      serReinit = 1'b1;
      repeat (4) @(negedge clk);
      chk(triggerOutput, 1'b0);
      serReinit = 1'b0;
      wr(7'h57, m[7:0]);
    end
    wr(7'h57, 8'h03);
    wr(7'h57, 8'h83);
    timestampInput = 1'b1;
    repeat (2) @(negedge clk);
    chk(triggerOutput, 1'b1);
    timestampInput = 1'b0;
    repeat (2) @(negedge clk);
    chk(triggerOutput, 1'b0);
    wr(7'h57, 8'h03);
    wr(7'h57, 8'h04);
    wr(7'h57, 8'h84);
    seen = 1'b0;
    repeat (80) @(negedge clk) seen = seen | triggerOutput;
    chk(seen, 1'b0);
    wr(7'h57, 8'h04);
    @(negedge clk);
    chk(triggerOutputEnable, 1'b0);
    $display("test_trig done");
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    run = 1'b1;
    test_regs;
    test_div;
    test_trig;
    wrap_up;
  end
  // The tests take about 4000 cycles; 40000 means a hang.
  initial begin
    #200000;
    mismatches++;
    wrap_up;
  end
endmodule
